/* src/dsp_link_if.sv */
// link between the sram device end and the controller end
// assumes: the bench joins both ends through one instance
`timescale 1ns/10ps
interface dsp_link_if #(
  parameter int N_BANK = dsp_pkg::N_BANK,
  parameter int ADDR_W = dsp_pkg::ADDR_W,
  parameter int WORD_W = dsp_pkg::WORD_W,
  parameter int LANES = dsp_pkg::LANES
);
  // input and output timing clocks
  logic k;
  logic kn;
  logic c;
  logic cn;
  // command, address, write data
  logic [N_BANK-1:0] access_select_n;
  logic rd_not_wr;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wr_data;
  logic [LANES-1:0] byte_lane_enable_n;
  logic delay_loop_off_n;
  // read data and echoes
  logic [WORD_W-1:0] rd_data;
  logic rd_data_oe;
  logic echo_strobe_pos;
  logic echo_strobe_neg;
  modport host (
    output k, kn, c, cn, access_select_n, rd_not_wr, addr, wr_data,
    output byte_lane_enable_n, delay_loop_off_n,
    input rd_data, rd_data_oe, echo_strobe_pos, echo_strobe_neg
  );
  modport dev (
    input k, kn, c, cn, access_select_n, rd_not_wr, addr, wr_data,
    input byte_lane_enable_n, delay_loop_off_n,
    output rd_data, rd_data_oe, echo_strobe_pos, echo_strobe_neg
  );
endinterface : dsp_link_if

/* src/dsp_pin_sync.sv */
// two-stage synchroniser for a bus of pin inputs
// assumes: each bit is a level; stage one feeds only stage two
`timescale 1ns/10ps
module dsp_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // pins and synchronised copy
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dsp_sync_st_t;
  dsp_sync_st_t s;
  dsp_sync_st_t next_s;

  // shift pins through both stages
  always_comb begin
    next_s.s1 = pin_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.s2;
endmodule : dsp_pin_sync

/* src/dsp_pkg.sv */
// shared constants and types for the ddr sio sram port ends
// assumes: both ends and the link interface import nothing
package dsp_pkg;
  // ----------
  // geometry
  // ----------
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int ADDR_W = 19;
  localparam int N_BANK = 1;
  localparam int IMP_W = 5;
  // ----------
  // timing
  // ----------
  localparam int CLK_NS = 4;
  localparam int STOP_NS = 30;
  localparam int STOP_CYC = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CYC = 1024;
  localparam int IMP_CYC = 1024;
  localparam int STRAP_WAIT = 6;
  localparam int K_HALF = 10;
  // ----------
  // host register map
  // ----------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WD0 = 8'h08;
  localparam logic [7:0] REG_WD1 = 8'h0C;
  localparam logic [7:0] REG_RD0 = 8'h10;
  localparam logic [7:0] REG_RD1 = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_BE = 4;
  localparam int CTRL_BANK = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RDV = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // host sequencer states
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_CMD = 5'h02,
    HS_WD0 = 5'h04,
    HS_WD1 = 5'h08,
    HS_RWAIT = 5'h10
  } dsp_host_st_t;
endpackage : dsp_pkg

/* src/dsp_sram_dev.sv */
// device end: ddr separate-io burst sram with two-word bursts
// assumes: link pins arrive unsynchronised; array lives in this module
//
// What this block does
// - command taken on k rise, lane enables on k and kn rise
// - write data taken on k and kn rise
// - read words launched on c/cn, or k/kn
// - load low, read high starts a read
// - word0 at cn rise t+1, word1 at t+2
// - two 18-bit words, low word first
// - new read accepted every k rise
// - finish reads, then float after c rise
// - load low, read low starts a write
// - write words at k then kn rise
// - new write accepted every k rise
// - idle writes ignore inputs after completion
// - lane enables sampled with each word
// - c and cn high at start: single clock
// - last write posted, committed by next write
// - controller gives each bank own load select
// - drive strength refreshed every 1024 cycles
// - echo strobes follow c/cn, or k/kn in single clock, freely
// - loop locks after 1024 stable k cycles
// - k slowed or stopped 30 ns resets lock
// - loop off: one cycle read latency
// - load high is no operation, outputs float
// - starts deselected with outputs floating
// - all lanes off writes nothing
`timescale 1ns/10ps
module dsp_sram_dev #(
  parameter int ADDR_W = dsp_pkg::ADDR_W,
  parameter int WORD_W = dsp_pkg::WORD_W,
  parameter int LANES = dsp_pkg::LANES,
  parameter int N_BANK = dsp_pkg::N_BANK,
  parameter int BANK_ID = 0,
  parameter int IMP_W = dsp_pkg::IMP_W
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // link to the controller
  dsp_link_if.dev lnk,
  // impedance and loop status
  input wire logic [IMP_W-1:0] impedance_resistor_i,
  output logic [IMP_W-1:0] drive_code_o,
  output logic dll_locked_o
);
  localparam int LW = dsp_pkg::LANE_W;
  localparam int BW = 2 * WORD_W;
  localparam int SW = 7 + ADDR_W + WORD_W + LANES + IMP_W;
  localparam int LCW = $clog2(dsp_pkg::LOCK_CYC);
  localparam int ICW = $clog2(dsp_pkg::IMP_CYC);

  typedef struct packed {
    logic [3:0] clk_prev;
    logic [2:0] strap_cnt;
    logic single;
    logic rd0_v;
    logic [ADDR_W-1:0] rd0_addr;
    logic rd1_v;
    logic [BW-1:0] rd1_data;
    logic w1_pend;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] q;
    logic q_oe;
    logic wa_v;
    logic [ADDR_W-1:0] wa_addr;
    logic wb_v;
    logic [ADDR_W-1:0] wb_addr;
    logic [WORD_W-1:0] wb_w0;
    logic [LANES-1:0] wb_be0;
    logic post_v;
    logic [ADDR_W-1:0] post_addr;
    logic [BW-1:0] post_data;
    logic [2*LANES-1:0] post_be;
    logic cq;
    logic cqn;
    logic [7:0] gap;
    logic [7:0] per;
    logic [LCW-1:0] lock_cnt;
    logic locked;
    logic [ICW-1:0] imp_cnt;
    logic [IMP_W-1:0] drive;
  } dsp_dev_st_t;

  dsp_dev_st_t s;
  dsp_dev_st_t next_s;
  logic [BW-1:0] mem [0:(1<<ADDR_W)-1];
  logic [SW-1:0] sy;
  logic k_s, kn_s, c_s, cn_s, ld_s, rw_s, off_n_s;
  logic [ADDR_W-1:0] a_s;
  logic [WORD_W-1:0] d_s;
  logic [LANES-1:0] be_n_s;
  logic [IMP_W-1:0] imp_s;
  logic k_r, kn_r, op_p, op_n, mem_we;
  logic [BW-1:0] fetched;
  logic [2*LANES-1:0] hit_be;

  // lane-wise merge, enabled lanes take the new byte
  function automatic logic [BW-1:0] merge(input logic [BW-1:0] base,
      input logic [BW-1:0] upd, input logic [2*LANES-1:0] be);
    logic [BW-1:0] m;
    m = base;
    for (int i = 0; i < 2 * LANES; i++) begin
      if (be[i]) begin
        m[i*LW +: LW] = upd[i*LW +: LW];
      end
    end
    return m;
  endfunction : merge

  // ----------
  // pin synchronisers
  // ----------
  dsp_pin_sync #(.W(SW)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i({lnk.k, lnk.kn, lnk.c, lnk.cn, lnk.access_select_n[BANK_ID],
      lnk.rd_not_wr, lnk.delay_loop_off_n, lnk.addr, lnk.wr_data,
      lnk.byte_lane_enable_n, impedance_resistor_i}),
    .sync_o(sy)
  );
  assign {k_s, kn_s, c_s, cn_s, ld_s, rw_s, off_n_s, a_s, d_s, be_n_s,
    imp_s} = sy;

  // ----------
  // next state
  // ----------
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    k_r = k_s & ~s.clk_prev[3];
    kn_r = kn_s & ~s.clk_prev[2];
    op_p = s.single ? k_r : (c_s & ~s.clk_prev[1]);
    op_n = s.single ? kn_r : (cn_s & ~s.clk_prev[0]);
    hit_be = (s.post_v && s.post_addr == s.rd0_addr) ? s.post_be : '0;
    fetched = merge(mem[s.rd0_addr], s.post_data, hit_be);
    next_s.clk_prev = {k_s, kn_s, c_s, cn_s};

    // strap caught once after reset
    // window outlasts both synchronisers, so the last sample is settled
    if (s.strap_cnt != 3'(dsp_pkg::STRAP_WAIT)) begin
      next_s.strap_cnt = s.strap_cnt + 3'h1;
      next_s.single = c_s & cn_s;
    end

    next_s.cq = s.single ? k_s : c_s;
    next_s.cqn = s.single ? kn_s : cn_s;

    if (op_p) begin
      if (off_n_s && s.w1_pend) begin
        next_s.q = s.w1;
        next_s.w1_pend = 1'b0;
      end else if (!s.w1_pend) begin
        next_s.q_oe = 1'b0;
      end
    end

    if (op_n) begin
      if (off_n_s && s.rd1_v) begin
        next_s.q = s.rd1_data[WORD_W-1:0];
        next_s.q_oe = 1'b1;
        next_s.w1 = s.rd1_data[BW-1:WORD_W];
        next_s.w1_pend = 1'b1;
        next_s.rd1_v = 1'b0;
      end else if (!off_n_s && s.w1_pend) begin
        next_s.q = s.w1;
        next_s.w1_pend = 1'b0;
      end
    end

    if (k_r) begin
      next_s.wb_v = s.wa_v;
      next_s.wb_addr = s.wa_addr;
      next_s.wb_w0 = d_s;
      next_s.wb_be0 = ~be_n_s;
      if (off_n_s) begin
        next_s.rd1_v = s.rd0_v;
        next_s.rd1_data = fetched;
      end else if (s.rd0_v) begin
        next_s.q = fetched[WORD_W-1:0];
        next_s.q_oe = 1'b1;
        next_s.w1 = fetched[BW-1:WORD_W];
        next_s.w1_pend = 1'b1;
      end
      next_s.rd0_v = !ld_s && rw_s;
      next_s.rd0_addr = a_s;
      next_s.wa_v = !ld_s && !rw_s;
      next_s.wa_addr = a_s;

      next_s.gap = 8'h01;
      next_s.per = s.gap;
      if (!off_n_s ||
          {1'b0, s.gap} > {1'b0, s.per} + 9'(dsp_pkg::STOP_CYC)) begin
        next_s.lock_cnt = '0;
        next_s.locked = 1'b0;
      end else if (s.lock_cnt == LCW'(dsp_pkg::LOCK_CYC - 1)) begin
        next_s.locked = 1'b1;
      end else begin
        next_s.lock_cnt = s.lock_cnt + 1'b1;
      end

      next_s.imp_cnt = s.imp_cnt + 1'b1;
      if (s.imp_cnt == ICW'(dsp_pkg::IMP_CYC - 1)) begin
        next_s.drive = imp_s;
      end
    end else if (s.gap != 8'hFF) begin
      next_s.gap = s.gap + 8'h01;
    end

    if (kn_r && s.wb_v) begin
      mem_we = s.post_v;
      next_s.post_v = 1'b1;
      next_s.post_addr = s.wb_addr;
      next_s.post_data = {d_s, s.wb_w0};
      next_s.post_be = {~be_n_s, s.wb_be0};
      next_s.wb_v = 1'b0;
    end
  end

  // ----------
  // registers
  // ----------
  // reset leaves outputs floating
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem[s.post_addr] <= merge(mem[s.post_addr], s.post_data, s.post_be);
    end
  end

  // outputs straight from state
  assign lnk.rd_data = s.q;
  assign lnk.rd_data_oe = s.q_oe;
  assign lnk.echo_strobe_pos = s.cq;
  assign lnk.echo_strobe_neg = s.cqn;
  assign drive_code_o = s.drive;
  assign dll_locked_o = s.locked;
endmodule : dsp_sram_dev

/* src/dsp_sram_host.sv */
// controller end: axi4-lite registers drive single sram accesses
// assumes: axi master on clk_sys_i; straps are static levels
`timescale 1ns/10ps
module dsp_sram_host #(
  parameter int ADDR_W = dsp_pkg::ADDR_W,
  parameter int WORD_W = dsp_pkg::WORD_W,
  parameter int LANES = dsp_pkg::LANES,
  parameter int N_BANK = dsp_pkg::N_BANK
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // board straps
  input wire logic single_clock_i,
  input wire logic delay_loop_off_n_i,
  // link to the sram
  dsp_link_if.host lnk
);
  localparam int BW = 2 * WORD_W;
  localparam int SW = 4 + WORD_W;
  localparam int KW = $clog2(dsp_pkg::K_HALF);

  typedef struct packed {
    dsp_pkg::dsp_host_st_t st;
    logic [KW-1:0] kcnt;
    logic k, kn, c, cn, delay_loop_off_n_n;
    logic [N_BANK-1:0] ld_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
    logic [LANES-1:0] be_n;
    logic go, c_rd;
    logic [7:0] c_bank;
    logic [2*LANES-1:0] c_be_n;
    logic [ADDR_W-1:0] c_addr;
    logic [BW-1:0] c_wd, rdat;
    logic rdv, ncap, cq_p, cqn_p;
    logic awr, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } dsp_host_reg_t;

  dsp_host_reg_t s;
  dsp_host_reg_t next_s;
  logic [SW-1:0] sy;
  logic sing_s, delay_loop_off_n_s, qoe_s, cq_s, cqn_s, pre_r, pre_f, busy;
  logic [WORD_W-1:0] q_s;

  dsp_pin_sync #(.W(SW)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i({lnk.rd_data, lnk.rd_data_oe, lnk.echo_strobe_pos,
      lnk.echo_strobe_neg, single_clock_i}),
    .sync_o(sy)
  );
  assign {q_s, qoe_s, cq_s, cqn_s, sing_s} = sy;

  // strap for the loop is held, not timed
  dsp_pin_sync #(.W(1)) u_delay_loop_off_n (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pin_i(delay_loop_off_n_i),
    .sync_o(delay_loop_off_n_s)
  );

  always_comb begin
    next_s = s;
    busy = s.go || s.st != dsp_pkg::HS_IDLE;
    pre_r = !s.k && s.kcnt == KW'(dsp_pkg::K_HALF / 2);
    pre_f = s.k && s.kcnt == KW'(dsp_pkg::K_HALF / 2);
    next_s.kcnt = s.kcnt + 1'b1;
    if (s.kcnt == KW'(dsp_pkg::K_HALF - 1)) begin
      next_s.kcnt = '0;
      next_s.k = ~s.k;
    end
    next_s.kn = ~next_s.k;
    // single clock holds c and cn high
    next_s.c = sing_s | next_s.k;
    next_s.cn = sing_s | ~next_s.k;
    next_s.delay_loop_off_n_n = delay_loop_off_n_s;
    next_s.cq_p = cq_s;
    next_s.cqn_p = cqn_s;

    // axi write: address and data taken together
    next_s.awr = !s.awr && !s.bv && s_axi_awvalid && s_axi_wvalid;
    if (s.awr) begin
      next_s.bv = 1'b1;
      next_s.bresp = dsp_pkg::RESP_OKAY;
      if (s_axi_awaddr == dsp_pkg::REG_CTRL) begin
        if (!busy) begin
          next_s.go = s_axi_wdata[dsp_pkg::CTRL_GO];
          next_s.c_rd = s_axi_wdata[dsp_pkg::CTRL_RD];
          next_s.c_be_n = s_axi_wdata[dsp_pkg::CTRL_BE +: 2*LANES];
          next_s.c_bank = s_axi_wdata[dsp_pkg::CTRL_BANK +: 8];
        end
      end else if (s_axi_awaddr == dsp_pkg::REG_ADDR) begin
        next_s.c_addr = s_axi_wdata[ADDR_W-1:0];
      end else if (s_axi_awaddr == dsp_pkg::REG_WD0) begin
        next_s.c_wd[WORD_W-1:0] = s_axi_wdata[WORD_W-1:0];
      end else if (s_axi_awaddr == dsp_pkg::REG_WD1) begin
        next_s.c_wd[BW-1:WORD_W] = s_axi_wdata[WORD_W-1:0];
      end else begin
        next_s.bresp = dsp_pkg::RESP_SLVERR;
      end
    end else if (s.bv && s_axi_bready) begin
      next_s.bv = 1'b0;
    end

    // axi read
    next_s.arr = !s.arr && !s.rv && s_axi_arvalid;
    if (s.arr) begin
      next_s.rv = 1'b1;
      next_s.rresp = dsp_pkg::RESP_OKAY;
      next_s.rdata = '0;
      if (s_axi_araddr == dsp_pkg::REG_CTRL) begin
        next_s.rdata = {16'h0000, s.c_bank, s.c_be_n, 2'h0, s.c_rd, s.go};
      end else if (s_axi_araddr == dsp_pkg::REG_ADDR) begin
        next_s.rdata = 32'(s.c_addr);
      end else if (s_axi_araddr == dsp_pkg::REG_WD0) begin
        next_s.rdata = 32'(s.c_wd[WORD_W-1:0]);
      end else if (s_axi_araddr == dsp_pkg::REG_WD1) begin
        next_s.rdata = 32'(s.c_wd[BW-1:WORD_W]);
      end else if (s_axi_araddr == dsp_pkg::REG_RD0) begin
        next_s.rdata = 32'(s.rdat[WORD_W-1:0]);
      end else if (s_axi_araddr == dsp_pkg::REG_RD1) begin
        next_s.rdata = 32'(s.rdat[BW-1:WORD_W]);
      end else if (s_axi_araddr == dsp_pkg::REG_STAT) begin
        next_s.rdata = {30'h00000000, s.rdv, busy};
      end else begin
        next_s.rresp = dsp_pkg::RESP_SLVERR;
      end
    end else if (s.rv && s_axi_rready) begin
      next_s.rv = 1'b0;
    end

    // access sequencer, pins change mid half-period
    case (s.st)
      dsp_pkg::HS_IDLE: begin
        if (s.go && pre_r) begin
          next_s.ld_n = ~(N_BANK'(1) << s.c_bank);
          next_s.rw = s.c_rd;
          next_s.addr = s.c_addr;
          next_s.go = 1'b0;
          next_s.rdv = 1'b0;
          next_s.st = dsp_pkg::HS_CMD;
        end
      end
      dsp_pkg::HS_CMD: begin
        if (pre_r) begin
          next_s.ld_n = '1;
          next_s.ncap = 1'b0;
          next_s.st = s.rw ? dsp_pkg::HS_RWAIT : dsp_pkg::HS_WD0;
          if (!s.rw) begin
            next_s.d = s.c_wd[WORD_W-1:0];
            next_s.be_n = s.c_be_n[LANES-1:0];
          end
        end
      end
      dsp_pkg::HS_WD0: begin
        if (pre_f) begin
          next_s.d = s.c_wd[BW-1:WORD_W];
          next_s.be_n = s.c_be_n[2*LANES-1:LANES];
          next_s.st = dsp_pkg::HS_WD1;
        end
      end
      dsp_pkg::HS_WD1: begin
        if (pre_r) begin
          next_s.be_n = '1;
          next_s.st = dsp_pkg::HS_IDLE;
        end
      end
      dsp_pkg::HS_RWAIT: begin
        if (qoe_s && ((cq_s && !s.cq_p) || (cqn_s && !s.cqn_p))) begin
          next_s.ncap = 1'b1;
          if (!s.ncap) begin
            next_s.rdat[WORD_W-1:0] = q_s;
          end else begin
            next_s.rdat[BW-1:WORD_W] = q_s;
            next_s.rdv = 1'b1;
            next_s.st = dsp_pkg::HS_IDLE;
          end
        end
      end
      default: begin
        next_s.st = dsp_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{st: dsp_pkg::HS_IDLE, kn: 1'b1, c: 1'b1, cn: 1'b1,
        ld_n: '1, be_n: '1, c_be_n: '1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign lnk.k = s.k;
  assign lnk.kn = s.kn;
  assign lnk.c = s.c;
  assign lnk.cn = s.cn;
  assign lnk.access_select_n = s.ld_n;
  assign lnk.rd_not_wr = s.rw;
  assign lnk.addr = s.addr;
  assign lnk.wr_data = s.d;
  assign lnk.byte_lane_enable_n = s.be_n;
  assign lnk.delay_loop_off_n = s.delay_loop_off_n_n;
  assign s_axi_awready = s.awr;
  assign s_axi_wready = s.awr;
  assign s_axi_bvalid = s.bv;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arr;
  assign s_axi_rvalid = s.rv;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
endmodule : dsp_sram_host

/* test/dsp_link_assertions.sv */
// checker for the sram link between the host and device ends
// assumes: instantiated in tb beside the link, one sys clock domain
`timescale 1ns/10ps
module dsp_link_assertions #(
  parameter int N_BANK = 1,
  parameter int ADDR_W = 19
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic k,
  input wire logic kn,
  input wire logic c,
  input wire logic cn,
  input wire logic [N_BANK-1:0] access_select_n,
  input wire logic rd_not_wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [17:0] wr_data,
  input wire logic [1:0] byte_lane_enable_n,
  input wire logic rd_data_oe,
  input wire logic echo_strobe_pos,
  input wire logic echo_strobe_neg
);
  // ----
  // load tracking
  // ----
  logic k_q;
  logic [7:0] since_rd;
  logic rd_load;
  logic wr_load;
  assign rd_load = k && !k_q && !access_select_n[0] && rd_not_wr;
  assign wr_load = k && !k_q && !access_select_n[0] && !rd_not_wr;
  // cycles since last read load, saturating
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_q <= 1'b0;
      since_rd <= 8'hFF;
    end else begin
      k_q <= k;
      if (rd_load) since_rd <= 8'h00;
      else if (since_rd != 8'hFF) since_rd <= since_rd + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // properties
  // ----
  kn_inverse_a: assert property (kn == ~k)
    else $error("kn not inverse of k");
  out_clk_a: assert property ((c == k && cn == kn) || (c && cn))
    else $error("output clocks neither k pair nor strapped");
  cmd_low_a: assert property (
    ($changed(access_select_n) || $changed(rd_not_wr) || $changed(addr))
    |-> !k) else $error("command changed while k high");
  data_mid_a: assert property (
    ($changed(wr_data) || $changed(byte_lane_enable_n)) |-> $stable(k))
    else $error("write data changed on a k edge");
  echo_pos_a: assert property (
    $rose(k) |-> ##[2:4] $rose(echo_strobe_pos))
    else $error("positive echo missed");
  echo_neg_a: assert property (
    $rose(kn) |-> ##[2:4] $rose(echo_strobe_neg))
    else $error("negative echo missed");
  oe_start_a: assert property (
    $rose(rd_data_oe) |-> since_rd >= 8'h10 && since_rd <= 8'h2C)
    else $error("read data started at wrong time");
  oe_bound_a: assert property (rd_data_oe |-> since_rd < 8'h50)
    else $error("read data driven without a read");
  idle_float_a: assert property (
    since_rd == 8'hFF |-> !rd_data_oe)
    else $error("outputs driven before first read");
  oe_finish_a: assert property (
    $fell(rd_data_oe) |-> since_rd > 8'h28)
    else $error("read burst cut short");
  cover property (rd_load);
  cover property (wr_load);
  cover property (rd_load ##20 rd_load);
endmodule : dsp_link_assertions

/* test/tb.sv */
// self-checking bench: host end over axi4-lite, device end on the link
// assumes: both ends share clk_sys_i and rst_n_i
`timescale 1ns/10ps
module tb;
  localparam int AW = 6;
  // ----
  // bench signals
  // ----
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lock;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic single_clk = 1'b0, dl_on_n = 1'b1;
  logic [4:0] imp = 5'h15;
  logic [4:0] drv;
  logic [17:0] ref0 [64];
  logic [17:0] ref1 [64];
  int miscompares = 0, checks_done = 0, cycles = 0;
  dsp_link_if #(.ADDR_W(AW)) lnk ();
  dsp_sram_host #(.ADDR_W(AW)) i_dsp_sram_host (.clk_sys_i, .rst_n_i,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .single_clock_i(single_clk),
    .delay_loop_off_n_i(dl_on_n), .lnk(lnk));
  dsp_sram_dev #(.ADDR_W(AW)) i_dsp_sram_dev (.clk_sys_i, .rst_n_i, .lnk(lnk),
    .impedance_resistor_i(imp), .drive_code_o(drv), .dll_locked_o(lock));
  dsp_link_assertions #(.ADDR_W(AW)) i_dsp_link_assertions (.clk_sys_i,
    .rst_n_i, .k(lnk.k), .kn(lnk.kn), .c(lnk.c), .cn(lnk.cn),
    .access_select_n(lnk.access_select_n), .rd_not_wr(lnk.rd_not_wr),
    .addr(lnk.addr), .wr_data(lnk.wr_data),
    .byte_lane_enable_n(lnk.byte_lane_enable_n),
    .rd_data_oe(lnk.rd_data_oe), .echo_strobe_pos(lnk.echo_strobe_pos),
    .echo_strobe_neg(lnk.echo_strobe_neg));
  // 250 MHz clock
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic reset(input logic sc, input logic on);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    single_clk <= sc;
    dl_on_n <= on;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask : reset
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // start one access and poll until idle
  task automatic go(input logic [5:0] a, input logic [31:0] ctrl);
    axi_wr(dsp_pkg::REG_ADDR, {26'h0, a});
    axi_wr(dsp_pkg::REG_CTRL, ctrl);
    v = 32'h1;
    while (v[0] !== 1'b0) axi_rd(dsp_pkg::REG_STAT);
  endtask : go
  task automatic wr_mem(input logic [5:0] a, input logic [3:0] be,
                        input logic [17:0] w0, input logic [17:0] w1);
    axi_wr(dsp_pkg::REG_WD0, {14'h0, w0});
    axi_wr(dsp_pkg::REG_WD1, {14'h0, w1});
    for (int j = 0; j < 2; j++) begin
      if (!be[j]) ref0[a][9*j +: 9] = w0[9*j +: 9];
      if (!be[j+2]) ref1[a][9*j +: 9] = w1[9*j +: 9];
    end
    go(a, {24'h0, be, 4'h1});
  endtask : wr_mem
  task automatic rd_mem(input logic [5:0] a);
    go(a, 32'h3);
    axi_rd(dsp_pkg::REG_RD0);
    chk(v, {14'h0, ref0[a]});
    axi_rd(dsp_pkg::REG_RD1);
    chk(v, {14'h0, ref1[a]});
    axi_rd(dsp_pkg::REG_STAT);
    chk(v, 32'h2);
  endtask : rd_mem
  // hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    reset(1'b0, 1'b1);
    axi_rd(dsp_pkg::REG_STAT);
    chk(v, 32'h0);
    axi_rd(8'h1C);
    chk({30'h0, r}, {30'h0, dsp_pkg::RESP_SLVERR});
    axi_wr(dsp_pkg::REG_RD0, 32'h1);
    chk({30'h0, r}, {30'h0, dsp_pkg::RESP_SLVERR});
    repeat (1000 * 2 * dsp_pkg::K_HALF) @(posedge clk_sys_i);
    chk({31'h0, lock}, 32'h0);
    chk({27'h0, drv}, 32'h0);
    repeat (64 * 2 * dsp_pkg::K_HALF) @(posedge clk_sys_i);
    chk({31'h0, lock}, 32'h1);
    chk({27'h0, drv}, {27'h0, imp});
    $display("test reset and lock done");
    wr_mem(6'h03, 4'h0, 18'h2A5C3, 18'h15A3C);
    rd_mem(6'h03);
    for (int i = 0; i < 4; i++) begin
      wr_mem(6'h03, {i[1:0], ~i[1:0]}, 18'h3F00F ^ 18'(i),
             18'h0C3C3 + 18'(i));
      rd_mem(6'h03);
    end
    $display("test lanes done");
    wr_mem(6'h05, 4'h0, 18'h11111, 18'h22222);
    rd_mem(6'h03);
    wr_mem(6'h06, 4'h0, 18'h33333, 18'h04444);
    rd_mem(6'h05);
    rd_mem(6'h06);
    $display("test posted write done");
    reset(1'b1, 1'b1);
    wr_mem(6'h07, 4'h0, 18'h0ABCD, 18'h35432);
    rd_mem(6'h07);
    $display("test single clock done");
    reset(1'b0, 1'b0);
    wr_mem(6'h09, 4'h0, 18'h1F0F0, 18'h20F0F);
    rd_mem(6'h09);
    chk({31'h0, lock}, 32'h0);
    $display("test loop off done");
    end_of_test();
  end
endmodule : tb
